// File: rtl/tmrcc_compare_top.sv
// Purpose: Two output compare channels of an 8-bit timer with Wishbone registers
// Assumes: Counter, its tick and direction come from logic on clk
// Notes: Classic Wishbone slave, ack one cycle after the request
// Overview of operation
// - Control bit 6 is the channel interrupt mask, reset 1, 1 lets events interrupt.
// - Control bits 5:3 pick the output action on a compare match, reset 000.
// - Code 000 sets, 001 clears, 010 toggles on match; 111 does nothing.
// - Code 011 sets on up match, clears at zero, or on down match in up/down.
// - Code 100 clears on up match, sets at zero, or on down match in up/down.
// - Channel 0: 101 sets on match, clears at FF; 110 clears, sets at zero.
// - Channel 1: 101/110 act on own match, opposite action on channel 0 match.
// - Channel 0 control bit 2 enables its compare operation, reset 0.
// - Channel 1 control bit 2 enables its compare operation, reset 0.
// - Channel 0 compare value is an 8-bit read/write register, reset 00.
// - Channel 1 compare value is an 8-bit read/write register, reset 00.
// - Shared counter value is compared against both channel values.
// - Compare event sets pending flag; writing 0 clears, writing 1 does nothing.
//
// The Wishbone register port was left to the implementer.
module tmrcc_compare_top (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tmrcc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [tmrcc_pkg::SEL_W-1:0] wb_sel_i,
  input wire logic [tmrcc_pkg::DATA_W-1:0] wb_dat_i,
  output logic [tmrcc_pkg::DATA_W-1:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [tmrcc_pkg::CNT_W-1:0] shared_counter_value,
  input wire logic count_tick,
  input wire logic count_down,
  input wire logic updown_mode,
  output logic ch0_compare_out,
  output logic ch1_compare_out,
  output logic ch0_compare_event,
  output logic ch1_compare_event,
  output logic irq
);
  import tmrcc_pkg::*;

  logic [CTRL_W-1:0] ctrl_ff [CH_N];
  logic [CTRL_W-1:0] nxt_ctrl [CH_N];
  logic [CNT_W-1:0] match_ff [CH_N];
  logic [CNT_W-1:0] nxt_match [CH_N];
  logic [CH_N-1:0] pend_ff;
  logic [CH_N-1:0] nxt_pend;
  logic [CH_N-1:0] stat_ff;
  logic [CH_N-1:0] nxt_stat;
  logic [CH_N-1:0] mask_ff;
  logic [CH_N-1:0] nxt_mask;
  logic ack_ff;
  logic nxt_ack;
  logic [DATA_W-1:0] rdat_ff;
  logic [DATA_W-1:0] nxt_rdat;
  logic [CH_N-1:0] ev_ff;
  logic [CH_N-1:0] hits;
  logic [CH_N-1:0] irq_en;
  logic req;
  logic wr;
  logic [IDX_W-1:0] idx;
  logic [CNT_W-1:0] wbyte;

  tmrcc_chan_if ch_if[CH_N] ();

  function automatic logic [DATA_W-1:0] tmrcc_zext(input logic [CNT_W-1:0] b);
    tmrcc_zext = {{(DATA_W-CNT_W){1'b0}}, b};
  endfunction

  function automatic logic [CNT_W-1:0] tmrcc_ctrl_rd(input logic [CTRL_W-1:0] c);
    tmrcc_ctrl_rd = {1'b0, c};
  endfunction

  // Channel wiring
  generate
    for (genvar g = 0; g < CH_N; g++) begin : g_ch
      assign ch_if[g].enable = ctrl_ff[g][EN_BIT];
      assign ch_if[g].action = tmrcc_act_t'(ctrl_ff[g][ACT_HI:ACT_LO]);
      assign ch_if[g].match_value = match_ff[g];
      assign ch_if[g].count = shared_counter_value;
      assign ch_if[g].tick = count_tick;
      assign ch_if[g].down = count_down;
      assign ch_if[g].updown = updown_mode;
      assign ch_if[g].aux_hit = (g == 1) ? ch_if[0].hit : 1'b0;
      assign hits[g] = ch_if[g].hit;
      assign irq_en[g] = ctrl_ff[g][IRQ_MASK_BIT];
    end
  endgenerate

  tmrcc_channel #(
    .IS_CH1(1'b0)
  ) u_ch0 (
    .clk(clk),
    .sys_rst(sys_rst),
    .ch(ch_if[0])
  );

  tmrcc_channel #(
    .IS_CH1(1'b1)
  ) u_ch1 (
    .clk(clk),
    .sys_rst(sys_rst),
    .ch(ch_if[1])
  );

  // Bus decode
  assign req = wb_cyc_i & wb_stb_i;
  assign idx = wb_adr_i[ADR_W-1:2];
  assign wr = req & ack_ff & wb_we_i & wb_sel_i[WR_LANE];
  assign wbyte = wb_dat_i[CNT_W-1:0];

  always_comb begin
    nxt_ack = req & ~ack_ff;
    nxt_rdat = DATA_ZERO;
    if (req & ~ack_ff & ~wb_we_i) begin
      case (idx)
        IDX_CH0_CTRL: nxt_rdat = tmrcc_zext(tmrcc_ctrl_rd(ctrl_ff[0]));
        IDX_CH0_MATCH: nxt_rdat = tmrcc_zext(match_ff[0]);
        IDX_CH1_CTRL: nxt_rdat = tmrcc_zext(tmrcc_ctrl_rd(ctrl_ff[1]));
        IDX_CH1_MATCH: nxt_rdat = tmrcc_zext(match_ff[1]);
        IDX_PEND: nxt_rdat = {{(DATA_W-CH_N){1'b0}}, pend_ff};
        IDX_IRQ_STAT: nxt_rdat = {{(DATA_W-CH_N){1'b0}}, stat_ff};
        IDX_IRQ_MASK: nxt_rdat = {{(DATA_W-CH_N){1'b0}}, mask_ff};
        default: nxt_rdat = DATA_ZERO;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ack_ff <= 1'b0;
      rdat_ff <= DATA_ZERO;
    end else begin
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  // Register file and flags
  always_comb begin
    for (int i = 0; i < CH_N; i++) begin
      nxt_ctrl[i] = ctrl_ff[i];
      nxt_match[i] = match_ff[i];
    end
    nxt_mask = mask_ff;
    nxt_pend = pend_ff;
    nxt_stat = stat_ff;
    if (wr) begin
      case (idx)
        IDX_CH0_CTRL: nxt_ctrl[0] = wbyte[CTRL_W-1:0];
        IDX_CH0_MATCH: nxt_match[0] = wbyte;
        IDX_CH1_CTRL: nxt_ctrl[1] = wbyte[CTRL_W-1:0];
        IDX_CH1_MATCH: nxt_match[1] = wbyte;
        IDX_PEND: nxt_pend = pend_ff & wbyte[CH_N-1:0];
        IDX_IRQ_STAT: nxt_stat = stat_ff & ~wbyte[CH_N-1:0];
        IDX_IRQ_MASK: nxt_mask = wbyte[CH_N-1:0];
        default: nxt_mask = mask_ff;
      endcase
    end
    nxt_pend = nxt_pend | hits;
    nxt_stat = nxt_stat | (hits & irq_en);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < CH_N; i++) begin
        ctrl_ff[i] <= CTRL_RST;
        match_ff[i] <= MATCH_RST;
      end
      pend_ff <= FLAG_RST;
      stat_ff <= FLAG_RST;
      mask_ff <= MASK_RST;
      ev_ff <= FLAG_RST;
    end else begin
      for (int i = 0; i < CH_N; i++) begin
        ctrl_ff[i] <= nxt_ctrl[i];
        match_ff[i] <= nxt_match[i];
      end
      pend_ff <= nxt_pend;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      ev_ff <= hits;
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign ch0_compare_out = ch_if[0].out;
  assign ch1_compare_out = ch_if[1].out;
  assign ch0_compare_event = ev_ff[0];
  assign ch1_compare_event = ev_ff[1];
  assign irq = |(stat_ff & mask_ff);
endmodule // tmrcc_compare_top

// File: rtl/tmrcc_pkg.sv
// Purpose: Shared constants for the timer compare channel block
// Assumes: Register indices are byte address divided by four
// Notes: Control fields sit in the low byte of each word
package tmrcc_pkg;
  localparam int DATA_W = 32;
  localparam int ADR_W = 12;
  localparam int SEL_W = 4;
  localparam int CNT_W = 8;
  localparam int IDX_W = 10;
  localparam int CH_N = 2;

  // Register indices (byte address is index times four)
  localparam logic [IDX_W-1:0] IDX_CH0_CTRL = 10'h0EC;
  localparam logic [IDX_W-1:0] IDX_CH0_MATCH = 10'h0ED;
  localparam logic [IDX_W-1:0] IDX_CH1_CTRL = 10'h0EE;
  localparam logic [IDX_W-1:0] IDX_CH1_MATCH = 10'h0EF;
  localparam logic [IDX_W-1:0] IDX_PEND = 10'h0F0;
  localparam logic [IDX_W-1:0] IDX_IRQ_STAT = 10'h0F1;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 10'h0F2;

  // Control register fields
  localparam int CTRL_W = 7;
  localparam int IRQ_MASK_BIT = 6;
  localparam int ACT_HI = 5;
  localparam int ACT_LO = 3;
  localparam int EN_BIT = 2;
  localparam int RSV_HI = 1;
  localparam int RSV_LO = 0;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h40;
  localparam logic [CNT_W-1:0] MATCH_RST = 8'h00;
  localparam logic [CH_N-1:0] FLAG_RST = 2'h0;
  localparam logic [CH_N-1:0] MASK_RST = 2'h0;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam logic [CNT_W-1:0] CNT_ONES = 8'hFF;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;
  localparam int WR_LANE = 0;

  typedef enum logic [2:0] {
    ACT_SET = 3'h0,
    ACT_CLR = 3'h1,
    ACT_TGL = 3'h2,
    ACT_SET_UP = 3'h3,
    ACT_CLR_UP = 3'h4,
    ACT_SET_AUX = 3'h5,
    ACT_CLR_AUX = 3'h6,
    ACT_NONE = 3'h7
  } tmrcc_act_t;
endpackage : tmrcc_pkg

// File: rtl/tmrcc_chan_if.sv
// Purpose: Bundle between register logic and one compare channel
// Assumes: All signals on clk
// Notes: aux_hit carries the channel 0 compare event to channel 1
interface tmrcc_chan_if;
  import tmrcc_pkg::*;
  logic enable;
  tmrcc_act_t action;
  logic [CNT_W-1:0] match_value;
  logic [CNT_W-1:0] count;
  logic tick;
  logic down;
  logic updown;
  logic aux_hit;
  logic hit;
  logic out;
  modport ctrl (output enable, action, match_value, count, tick, down, updown, aux_hit, input hit, out);
  modport chan (input enable, action, match_value, count, tick, down, updown, aux_hit, output hit, out);
endinterface : tmrcc_chan_if

// File: rtl/tmrcc_channel.sv
// Purpose: One compare channel: match detection and output action
// Assumes: tick marks a counter update, count is the value after it
// Notes: On simultaneous set and clear, the set action wins, except in code 110 where the clear on match wins
module tmrcc_channel #(
  parameter bit IS_CH1 = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  tmrcc_chan_if.chan ch
);
  import tmrcc_pkg::*;

  logic out_ff;
  logic nxt_out;
  logic hit;
  logic zero;
  logic ends;
  logic starts;
  logic set_o;
  logic clr_o;

  always_comb begin
    hit = ch.enable & ch.tick & (ch.count == ch.match_value);
    zero = ch.enable & ch.tick & (ch.count == CNT_ZERO);
    ends = IS_CH1 ? (ch.enable & ch.aux_hit) : (ch.enable & ch.tick & (ch.count == CNT_ONES));
    starts = IS_CH1 ? (ch.enable & ch.aux_hit) : zero;
    set_o = 1'b0;
    clr_o = 1'b0;
    nxt_out = out_ff;
    case (ch.action)
      ACT_SET: set_o = hit;
      ACT_CLR: clr_o = hit;
      ACT_TGL: begin
        set_o = hit & ~out_ff;
        clr_o = hit & out_ff;
      end
      ACT_SET_UP: begin
        set_o = hit & ~(ch.updown & ch.down);
        clr_o = ch.updown ? (hit & ch.down) : zero;
      end
      ACT_CLR_UP: begin
        clr_o = hit & ~(ch.updown & ch.down);
        set_o = ch.updown ? (hit & ch.down) : zero;
      end
      ACT_SET_AUX: begin
        set_o = hit;
        clr_o = ends & ~hit;
      end
      ACT_CLR_AUX: begin
        clr_o = hit;
        set_o = starts & ~hit;
      end
      default: begin
        set_o = 1'b0;
        clr_o = 1'b0;
      end
    endcase
    if (set_o) begin
      nxt_out = 1'b1;
    end else if (clr_o) begin
      nxt_out = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      out_ff <= 1'b0;
    end else begin
      out_ff <= nxt_out;
    end
  end

  assign ch.hit = hit;
  assign ch.out = out_ff;
endmodule // tmrcc_channel

// File: verification/tmrcc_compare_properties.sv
// Purpose: Port assertions for the compare block
// Assumes: One clock, synchronous reset
// Notes: Bound into tmrcc_compare_top
module tmrcc_compare_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [tmrcc_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [tmrcc_pkg::DATA_W-1:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic count_tick,
  input wire logic ch0_compare_out,
  input wire logic ch1_compare_out,
  input wire logic ch0_compare_event,
  input wire logic ch1_compare_event
);
  timeunit 1ns;
  timeprecision 1ps;
  import tmrcc_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held");
  ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  read_idle_a: assert property (!wb_ack_o |-> wb_dat_o == DATA_ZERO) else $error("data not idle");
  ctrl_top_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[3:2] inside {2'h0, 2'h2}
    && wb_adr_i[11:4] == 8'h3B |-> wb_dat_o[31:7] == 25'h0) else $error("ctrl top bits");
  ev0_tick_a: assert property (ch0_compare_event |-> $past(count_tick)) else $error("ch0 event");
  ev1_tick_a: assert property (ch1_compare_event |-> $past(count_tick)) else $error("ch1 event");
  out0_tick_a: assert property ($changed(ch0_compare_out) |-> $past(count_tick)) else $error("ch0 out");
  out1_tick_a: assert property ($changed(ch1_compare_out) |-> $past(count_tick)) else $error("ch1 out");
endmodule // tmrcc_compare_properties

bind tmrcc_compare_top tmrcc_compare_properties u_props (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
  .wb_adr_i, .wb_dat_o, .wb_ack_o, .count_tick, .ch0_compare_out, .ch1_compare_out, .ch0_compare_event,
  .ch1_compare_event);

// File: verification/tmrcc_counter_model.sv
// Purpose: Counter feeding the compare block, free running or up/down
// Assumes: One tick per clock while run is high; top is the channel 0 compare value
// Notes: Free running wraps from FF to 00; up/down turns at top and at zero
module tmrcc_counter_model (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic run,
  input wire logic updown,
  input wire logic [tmrcc_pkg::CNT_W-1:0] top,
  output logic [tmrcc_pkg::CNT_W-1:0] cnt,
  output logic tick,
  output logic down
);
  timeunit 1ns;
  timeprecision 1ps;
  import tmrcc_pkg::*;
  logic [CNT_W-1:0] cnt_ff;
  logic tick_ff;
  logic down_ff;
  always_ff @(posedge clk) begin
    if (sys_rst || !run) begin
      cnt_ff <= CNT_ZERO;
      tick_ff <= 1'b0;
      down_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b1;
      if (updown && !down_ff && cnt_ff == top) begin
        down_ff <= 1'b1;
        cnt_ff <= cnt_ff - 8'h01;
      end else if (updown && down_ff && cnt_ff == CNT_ZERO) begin
        down_ff <= 1'b0;
        cnt_ff <= cnt_ff + 8'h01;
      end else if (updown && down_ff) begin
        cnt_ff <= cnt_ff - 8'h01;
      end else begin
        down_ff <= 1'b0;
        cnt_ff <= cnt_ff + 8'h01;
      end
    end
  end
  assign cnt = cnt_ff;
  assign tick = tick_ff;
  assign down = down_ff;
endmodule // tmrcc_counter_model

// File: verification/tb.sv
// Purpose: Self-checking bench for the compare block
// Assumes: Counter model runs freely once started
// Notes: Registers reached over classic Wishbone
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tmrcc_pkg::*;
  logic clk = 0, sys_rst = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, run = 0, updown_mode = 0;
  logic count_down;
  logic [ADR_W-1:0] wb_adr_i = 12'h000;
  logic [SEL_W-1:0] wb_sel_i = 4'h1;
  logic [DATA_W-1:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, count_tick, ch0_compare_out, ch1_compare_out, ch0_compare_event, ch1_compare_event, irq;
  logic [CNT_W-1:0] shared_counter_value;
  int err_total = 0, checked = 0, cyc_n = 0;
  logic [2:0] codes [9] = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h5, 3'h6, 3'h4, 3'h3, 3'h7};
  logic ex_hit [9] = '{1, 0, 1, 0, 1, 0, 0, 1, 0};
  logic ex_late [9] = '{1, 0, 1, 0, 0, 1, 1, 0, 0};
  always #2 clk = ~clk;
  tmrcc_compare_top dut (.clk, .sys_rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_dat_o, .wb_ack_o, .shared_counter_value, .count_tick, .count_down, .updown_mode,
    .ch0_compare_out, .ch1_compare_out, .ch0_compare_event, .ch1_compare_event, .irq);
  // Up/down top matches the channel 0 compare value written in t_updn
  tmrcc_counter_model u_cnt (.clk, .sys_rst, .run, .updown(updown_mode), .top(8'h40),
    .cnt(shared_counter_value), .tick(count_tick), .down(count_down));
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc_n++;
    if (cyc_n == 30000) begin
      err_total++;
      finish_test();
    end
  end
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, a, d};
    do @(posedge clk); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(n, rd, e);
  endtask
  task automatic wait_ev(input logic ch);
    int i;
    i = 0;
    while (i < 600 && (ch ? ch1_compare_event : ch0_compare_event) !== 1'b1) begin
      @(posedge clk);
      i++;
    end
    chk("event", {31'h0, i < 600}, 32'h1);
  endtask
  task automatic t_reset;
    chk("out0", {31'h0, ch0_compare_out}, 32'h0);
    rdchk("ctrl0", 12'h3B0, 32'h40);
    rdchk("val0", 12'h3B4, 32'h0);
    rdchk("ctrl1", 12'h3B8, 32'h40);
    rdchk("val1", 12'h3BC, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_regs;
    wb(1'b1, 12'h3B4, 32'hA5);
    rdchk("val0", 12'h3B4, 32'hA5);
    wb(1'b1, 12'h3BC, 32'h5A);
    rdchk("val1", 12'h3BC, 32'h5A);
    wb(1'b1, 12'h3B8, 32'hFC);
    rdchk("ctrl1", 12'h3B8, 32'h7C);
    wb(1'b1, 12'h3B8, 32'h40);
    wb(1'b1, 12'h000, 32'hFF);
    rdchk("unmapped", 12'h000, 32'h0);
    $display("test registers done");
  endtask
  task automatic t_codes;
    wb(1'b1, 12'h3B4, 32'h10);
    run <= 1'b1;
    repeat (300) @(posedge clk);
    chk("out0", {31'h0, ch0_compare_out}, 32'h0);
    rdchk("pend", 12'h3C0, 32'h0);
    for (int k = 0; k < 9; k++) begin
      wb(1'b1, 12'h3B0, {26'h1, codes[k], 3'h4});
      wait_ev(1'b0);
      chk("out0", {31'h0, ch0_compare_out}, {31'h0, ex_hit[k]});
      repeat (245) @(posedge clk);
      chk("out0", {31'h0, ch0_compare_out}, {31'h0, ex_late[k]});
    end
    wb(1'b1, 12'h3B0, 32'h40);
    $display("test codes done");
  endtask
  task automatic t_irq;
    rdchk("pend", 12'h3C0, 32'h1);
    wb(1'b1, 12'h3C0, 32'h3);
    rdchk("pend", 12'h3C0, 32'h1);
    wb(1'b1, 12'h3C0, 32'h0);
    rdchk("pend", 12'h3C0, 32'h0);
    chk("irq", {31'h0, irq}, 32'h0);
    wb(1'b1, 12'h3C8, 32'h1);
    @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h1);
    wb(1'b1, 12'h3C4, 32'h1);
    @(posedge clk);
    chk("irq", {31'h0, irq}, 32'h0);
    $display("test interrupt done");
  endtask
  task automatic t_ch1;
    wb(1'b1, 12'h3B4, 32'h80);
    wb(1'b1, 12'h3B0, 32'h7C);
    wb(1'b1, 12'h3BC, 32'h10);
    wb(1'b1, 12'h3B8, 32'h2C);
    wait_ev(1'b1);
    chk("out1", {31'h0, ch1_compare_out}, 32'h1);
    wait_ev(1'b0);
    chk("out1", {31'h0, ch1_compare_out}, 32'h0);
    wb(1'b1, 12'h3B8, 32'h34);
    wait_ev(1'b1);
    chk("out1", {31'h0, ch1_compare_out}, 32'h0);
    wait_ev(1'b0);
    chk("out1", {31'h0, ch1_compare_out}, 32'h1);
    rdchk("stat", 12'h3C4, 32'h1);
    rdchk("pend", 12'h3C0, 32'h3);
    $display("test channel link done");
  endtask
  task automatic t_updn;
    wb(1'b1, 12'h3B4, 32'h40);
    wb(1'b1, 12'h3BC, 32'h20);
    updown_mode <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      wb(1'b1, 12'h3B8, k ? 32'h64 : 32'h5C);
      for (int j = 0; j < 2; j++) begin
        repeat (2) @(posedge clk);
        wait_ev(1'b1);
        chk("out1", {31'h0, ch1_compare_out}, {31'h0, k[0] ^ ~count_down});
      end
    end
    updown_mode <= 1'b0;
    $display("test up down done");
  endtask
  initial begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_regs();
    t_codes();
    t_irq();
    t_ch1();
    t_updn();
    finish_test();
  end
endmodule // tb
